// ---- sleep_gate_pkg.sv ----
// Constants, types and helpers shared by the sleep-mode clock gating block
package sleep_gate_pkg;

    // ****************************************************************
    // Register map (byte addresses on the APB port)
    // ****************************************************************
    localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h118;
    localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h200;
    localparam logic [11:0] EVENT_MASK_OFFSET = 12'h204;
    localparam logic [11:0] FAULT_INFO_OFFSET = 12'h208;
    localparam logic [11:0] ACTIVE_GATE_OFFSET = 12'h20c;

    // ****************************************************************
    // Gating register layout and reset
    // ****************************************************************
    localparam logic [31:0] SLEEP_GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] SLEEP_GATE_WRITABLE = 32'h5000_007f;
    localparam int PHY_GATE_BIT = 30;
    localparam int MAC_GATE_BIT = 28;
    localparam int PORT_G_GATE_BIT = 6;
    localparam int PORT_A_GATE_BIT = 0;

    // Controlled units: ports A..G are 0..6, MAC is 7, PHY is 8
    localparam int NUM_UNITS = 9;
    localparam int UNIT_MAC = 7;
    localparam int UNIT_PHY = 8;
    localparam logic [8:0] UNIT_GATE_RESET = 9'h000;

    // ****************************************************************
    // Event status layout
    // ****************************************************************
    localparam int NUM_EVENTS = 2;
    localparam int EVT_BUS_FAULT = 0;
    localparam int EVT_MODE_CHANGE = 1;
    localparam logic [1:0] EVENT_RESET = 2'h0;
    localparam logic [4:0] FAULT_INFO_RESET = 5'h00;
    localparam int FAULT_INFO_WRITE_BIT = 4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP_SLEEP = 2'b10
    } power_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] unit;
    } unit_access_t;

    // Gather the writable gating bits into one enable per unit
    function automatic logic [8:0] unit_gates(input logic [31:0] r);
        unit_gates = {r[PHY_GATE_BIT], r[MAC_GATE_BIT], r[PORT_G_GATE_BIT:PORT_A_GATE_BIT]};
    endfunction : unit_gates

endpackage : sleep_gate_pkg

// ---- unit_gate_mux.sv ----
// Per-unit selection of the gating set that applies in the current power mode
`timescale 1ns/1ps
module unit_gate_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire sleep_gate_pkg::power_mode_t mode,
    input wire logic auto_clock_gating,
    input wire logic [8:0] run_gate,
    input wire logic [8:0] sleep_gate,
    input wire logic [8:0] deep_gate,
    output logic [8:0] unit_clk_en
);

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire logic use_sleep;
    wire logic use_deep;
    // Without automatic gating the run set stays in force in every mode
    assign use_sleep = auto_clock_gating && (mode == sleep_gate_pkg::MODE_SLEEP);
    assign use_deep = auto_clock_gating && (mode == sleep_gate_pkg::MODE_DEEP_SLEEP);

    // ****************************************************************
    // One registered enable per unit
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < sleep_gate_pkg::NUM_UNITS; i = i + 1) begin : g_unit
            wire logic en_next;
            assign en_next = use_sleep ? sleep_gate[i] : (use_deep ? deep_gate[i] : run_gate[i]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    unit_clk_en[i] <= 1'b0;
                end else begin
                    unit_clk_en[i] <= en_next;
                end
            end
        end
    endgenerate

endmodule : unit_gate_mux

// ---- event_status.sv ----
// Sticky event status with read-to-clear, mask and one level interrupt
`timescale 1ns/1ps
module event_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] events,
    input wire logic [1:0] clr_bits,
    input wire logic mask_we,
    input wire logic [1:0] mask_wdata,
    output logic [1:0] status_reg,
    output logic [1:0] mask_reg,
    output logic irq
);

    // ****************************************************************
    // Status and mask
    // ****************************************************************
    wire logic [1:0] status_next;
    // A new event in the clearing cycle survives the clear
    assign status_next = (status_reg & ~clr_bits) | events;
    assign irq = |(status_reg & mask_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= sleep_gate_pkg::EVENT_RESET;
            mask_reg <= sleep_gate_pkg::EVENT_RESET;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_we ? mask_wdata : mask_reg;
        end
    end

endmodule : event_status

// ---- sleep_clock_gate_control.sv ----
// Sleep-mode clock gating register with APB access and bus fault detection
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module sleep_clock_gate_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sleep_gate_pkg::power_mode_t mode,
    input wire logic auto_clock_gating,
    input wire logic [8:0] run_gate,
    input wire logic [8:0] deep_sleep_gate,
    input wire sleep_gate_pkg::unit_access_t unit_access,
    output logic unit_bus_fault,
    output logic [8:0] unit_clk_en,
    output logic irq
);

    // ****************************************************************
    // APB phase decode
    // ****************************************************************
    wire logic setup_phase;
    wire logic access_done;
    wire logic wr_done;
    wire logic rd_done;
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign wr_done = access_done && pwrite;
    assign rd_done = access_done && !pwrite;
    // Zero wait states: every access phase completes in its first cycle
    assign pready = 1'b1;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic hit_gate;
    wire logic hit_status;
    wire logic hit_mask;
    wire logic hit_fault_info;
    wire logic hit_active;
    wire logic hit_any;
    assign hit_gate = (paddr == sleep_gate_pkg::SLEEP_GATE_OFFSET);
    assign hit_status = (paddr == sleep_gate_pkg::EVENT_STATUS_OFFSET);
    assign hit_mask = (paddr == sleep_gate_pkg::EVENT_MASK_OFFSET);
    assign hit_fault_info = (paddr == sleep_gate_pkg::FAULT_INFO_OFFSET);
    assign hit_active = (paddr == sleep_gate_pkg::ACTIVE_GATE_OFFSET);
    assign hit_any = hit_gate || hit_status || hit_mask || hit_fault_info || hit_active;

    // ****************************************************************
    // Sleep gating register
    // ****************************************************************
    logic [31:0] sleep_gate_reg;
    wire logic [31:0] lane_mask;
    wire logic [31:0] sleep_gate_merged;
    wire logic [31:0] sleep_gate_next;
    wire logic [8:0] sleep_units;
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign sleep_gate_merged = (sleep_gate_reg & ~lane_mask) | (pwdata & lane_mask);
    // Reserved positions are never stored, so they always read back zero
    assign sleep_gate_next = sleep_gate_merged & sleep_gate_pkg::SLEEP_GATE_WRITABLE;
    // Port bits map to units 0..6, MAC to 7, PHY to 8
    assign sleep_units = sleep_gate_pkg::unit_gates(sleep_gate_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_gate_reg <= sleep_gate_pkg::SLEEP_GATE_RESET;
        end else if (wr_done && hit_gate) begin
            sleep_gate_reg <= sleep_gate_next;
        end
    end

    // ****************************************************************
    // Active gating set per power mode
    // ****************************************************************
    unit_gate_mux u_gate_mux (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode),
        .auto_clock_gating(auto_clock_gating),
        .run_gate(run_gate),
        .sleep_gate(sleep_units),
        .deep_gate(deep_sleep_gate),
        .unit_clk_en(unit_clk_en)
    );

    // ****************************************************************
    // Bus fault on access to an unclocked unit
    // ****************************************************************
    wire logic unit_known;
    wire logic unit_gated;
    assign unit_known = (unit_access.unit < 4'(sleep_gate_pkg::NUM_UNITS));
    assign unit_gated = unit_known && !unit_clk_en[unit_access.unit];
    // Combinational so the fault answers the access in its own cycle
    assign unit_bus_fault = unit_access.valid && unit_gated;

    // Last faulting access: unit number and direction
    logic [4:0] fault_info_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_info_reg <= sleep_gate_pkg::FAULT_INFO_RESET;
        end else if (unit_bus_fault) begin
            fault_info_reg <= {unit_access.write, unit_access.unit};
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    sleep_gate_pkg::power_mode_t mode_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= sleep_gate_pkg::MODE_RUN;
        end else begin
            mode_reg <= mode;
        end
    end

    wire logic [1:0] events;
    assign events[sleep_gate_pkg::EVT_BUS_FAULT] = unit_bus_fault;
    assign events[sleep_gate_pkg::EVT_MODE_CHANGE] = (mode != mode_reg);

    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [1:0] status_snap_reg;
    wire logic [1:0] clr_bits;
    wire logic mask_we;
    // Only bits that were returned by the read are cleared, so events that
    // arrive between setup and completion are kept
    assign clr_bits = (rd_done && hit_status) ? status_snap_reg : 2'h0;
    assign mask_we = wr_done && hit_mask && pstrb[0];

    event_status u_events (
        .pclk(pclk),
        .presetn(presetn),
        .events(events),
        .clr_bits(clr_bits),
        .mask_we(mask_we),
        .mask_wdata(pwdata[1:0]),
        .status_reg(status_reg),
        .mask_reg(mask_reg),
        .irq(irq)
    );

    // ****************************************************************
    // Read data and error, captured in the setup cycle
    // ****************************************************************
    wire logic [31:0] read_value;
    assign read_value = hit_gate ? sleep_gate_reg :
                        hit_status ? {30'h0, status_reg} :
                        hit_mask ? {30'h0, mask_reg} :
                        hit_fault_info ? {27'h0, fault_info_reg} :
                        hit_active ? {23'h0, unit_clk_en} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
            status_snap_reg <= 2'h0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0 : read_value;
            pslverr <= !hit_any;
            status_snap_reg <= status_reg;
        end else if (access_done) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
            status_snap_reg <= 2'h0;
        end
    end

endmodule : sleep_clock_gate_control

// ---- sleep_gate_monitor.sv ----
// Concurrent checks on the ports of the sleep gating block
`timescale 1ns/1ps
module sleep_gate_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire sleep_gate_pkg::power_mode_t mode,
    input wire logic auto_clock_gating,
    input wire logic [8:0] run_gate,
    input wire logic [8:0] deep_sleep_gate,
    input wire sleep_gate_pkg::unit_access_t unit_access,
    input wire logic unit_bus_fault,
    input wire logic [8:0] unit_clk_en
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire slp = auto_clock_gating && mode == sleep_gate_pkg::MODE_SLEEP;
    wire hit = unit_access.valid && unit_access.unit < 4'h9;
    a_reset_clear: assert property ($rose(presetn) |-> unit_clk_en == 9'h000)
        else $error("unit enables not clear after reset");
    a_fault_gated: assert property (hit && !unit_clk_en[unit_access.unit] |-> unit_bus_fault)
        else $error("no fault on gated unit");
    a_fault_clocked: assert property (hit && unit_clk_en[unit_access.unit] |-> !unit_bus_fault)
        else $error("fault on clocked unit");
    a_run_set: assert property (mode == sleep_gate_pkg::MODE_RUN |=> unit_clk_en == $past(run_gate))
        else $error("run set not applied");
    a_deep_set: assert property (auto_clock_gating
        && mode == sleep_gate_pkg::MODE_DEEP_SLEEP
        |=> unit_clk_en == $past(deep_sleep_gate)) else $error("deep set not applied");
    a_acg_off: assert property (!auto_clock_gating |=> unit_clk_en == $past(run_gate))
        else $error("run set not kept with gating off");
    a_rsvd_zero: assert property (acc && !pwrite && paddr == 12'h118
        |-> (prdata & 32'hafff_ff80) == 32'h0) else $error("reserved bits read nonzero");
    a_map_ok: assert property (acc && paddr == 12'h118 |-> !pslverr)
        else $error("error on gating register");
    a_unmap_err: assert property (acc && !(paddr inside {12'h118, 12'h200, 12'h204,
        12'h208, 12'h20c}) |-> pslverr) else $error("no error on unmapped address");
    // Quiet sleep cycles with no write: the sleep set must hold steady
    a_sleep_hold: assert property ((slp && !(psel && pwrite))[*3] |=> $stable(unit_clk_en))
        else $error("sleep enables moved without a write");
endmodule : sleep_gate_monitor

// ---- apb_master_model.sv ----
// Processor-side APB master that programs the gating block
`timescale 1ns/1ps
module apb_master_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ****************************************************************
    // Bus transfers
    // ****************************************************************
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so a stale value cannot pass
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    task automatic rmw(input logic [11:0] a, input logic [31:0] clr, input logic [31:0] set);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        xfer(1'b1, a, (q & ~clr) | set, q, e);
    endtask : rmw
endmodule : apb_master_model

// ---- tb_top.sv ----
// Self-checking testbench for the sleep gating block
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic auto_clock_gating = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, unit_bus_fault, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [8:0] run_gate = 9'h000;
    logic [8:0] deep_sleep_gate = 9'h000;
    logic [8:0] unit_clk_en;
    sleep_gate_pkg::power_mode_t mode = sleep_gate_pkg::MODE_RUN;
    sleep_gate_pkg::unit_access_t unit_access = '0;
    int bad_count = 0;
    int tests_run = 0;
    int pos[9] = '{0, 1, 2, 3, 4, 5, 6, 28, 30};
    localparam logic [11:0] OFS = sleep_gate_pkg::SLEEP_GATE_OFFSET;
    always #10 pclk = ~pclk;
    apb_master_model i_apb_master_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr);
    sleep_clock_gate_control i_sleep_clock_gate_control (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mode, .auto_clock_gating,
        .run_gate, .deep_sleep_gate, .unit_access, .unit_bus_fault, .unit_clk_en, .irq);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        i_apb_master_model.xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_apb_master_model.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic t_bits();
        auto_clock_gating <= 1'b1;
        mode <= sleep_gate_pkg::MODE_SLEEP;
        for (int i = 0; i < 9; i++) begin
            wr(OFS, 32'h1 << pos[i]);
            rd(OFS, 32'h1 << pos[i], 1'b0);
            chk({23'h0, unit_clk_en}, 32'h1 << i);
        end
        wr(OFS, 32'hffff_ffff);
        rd(OFS, 32'h5000_007f, 1'b0);
    endtask : t_bits
    task automatic t_modes();
        run_gate <= 9'h0a5;
        deep_sleep_gate <= 9'h15a;
        auto_clock_gating <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({23'h0, unit_clk_en}, 32'h0a5);
        auto_clock_gating <= 1'b1;
        mode <= sleep_gate_pkg::MODE_DEEP_SLEEP;
        repeat (2) @(posedge pclk);
        chk({23'h0, unit_clk_en}, 32'h15a);
        mode <= sleep_gate_pkg::MODE_SLEEP;
    endtask : t_modes
    task automatic t_fault();
        i_apb_master_model.rmw(OFS, 32'h8, 32'h0);
        repeat (2) @(posedge pclk);
        unit_access <= '{1'b1, 1'b0, 4'h3};
        #1 chk({31'h0, unit_bus_fault}, 32'h1);
        @(posedge pclk) unit_access <= '{1'b1, 1'b1, 4'h4};
        #1 chk({31'h0, unit_bus_fault}, 32'h0);
        @(posedge pclk) unit_access <= '0;
        // Mask still clear, so the fault must stay silent until unmasked
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(sleep_gate_pkg::EVENT_MASK_OFFSET, 32'h1);
        @(posedge pclk) #1 chk({31'h0, irq}, 32'h1);
        rd(sleep_gate_pkg::EVENT_STATUS_OFFSET, 32'h3, 1'b0);
        @(posedge pclk) #1 chk({31'h0, irq}, 32'h0);
        rd(12'h300, 32'h0, 1'b1);
        // Only the port D access faulted, and the record is read-only
        rd(sleep_gate_pkg::FAULT_INFO_OFFSET, 32'h3, 1'b0);
        wr(sleep_gate_pkg::FAULT_INFO_OFFSET, 32'hffff_ffff);
        rd(sleep_gate_pkg::FAULT_INFO_OFFSET, 32'h3, 1'b0);
        // Sleep set 0x50000077 leaves every unit but port D clocked
        rd(sleep_gate_pkg::ACTIVE_GATE_OFFSET, 32'h1f7, 1'b0);
    endtask : t_fault
    task automatic t_reset();
        // Mid-run reset must drop the programmed set, not only the power-up state
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({23'h0, unit_clk_en}, 32'h0);
        presetn <= 1'b1;
        rd(OFS, sleep_gate_pkg::SLEEP_GATE_RESET, 1'b0);
        chk({23'h0, unit_clk_en}, 32'h0);
    endtask : t_reset
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk({23'h0, unit_clk_en}, 32'h0);
        rd(OFS, sleep_gate_pkg::SLEEP_GATE_RESET, 1'b0);
        t_bits();
        t_modes();
        t_fault();
        t_reset();
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
endmodule : tb_top
bind sleep_clock_gate_control sleep_gate_monitor i_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pslverr, .mode, .auto_clock_gating, .run_gate,
    .deep_sleep_gate, .unit_access, .unit_bus_fault, .unit_clk_en);
